/* hdl/rsg_sequencer.sv */
// Contract
// - Supply fail drives all three reset outputs low at once.
// - After supply recovers, release first, then second, then third.
// - Released outputs stay high until new supply fail or manual reset.
// - Power-up hold equals selected delay, counted from supply in tolerance.
// - Tolerance select sampled only while supply below lowest trip level.
// - Tolerance select picks one of three trip thresholds.
// - Manual request starts a new reset cycle when outputs not held.
// - Manual reset held low forces all outputs active.
// - Manual release runs same sequenced release timed by delay select.
// - Manual reset input is debounced internally.
// - Delay select decoded as high, low or floating.
// - First output hold at least 10, 20 or 50 ms.
// - All delays come from one divider chain.
// - Second delay five times first, third ten times first.
// - Stable low manual input to outputs active in 1.0 to 2.0 ms.
`timescale 1ns/1ps
module rsg_sequencer
   import rsg_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int DEB_TICKS = DEBOUNCE_TICKS
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic SUPPLY_FAIL,
   input wire logic SUPPLY_BELOW_MIN,
   input wire logic MANUAL_RESET_N,
   input wire rsg_pin3_t DELAY_SELECT,
   input wire rsg_pin3_t TOLERANCE_SELECT,
   output rsg_resets_t RESET_OUT,
   output logic [1:0] SUPPLY_TRIP_POINT
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [6:0] pins_raw;
   logic [6:0] pins_s;
   logic fail_s;
   logic below_s;
   logic button_s;
   rsg_pin3_t delay_pin_s;
   rsg_pin3_t tol_pin_s;

   assign pins_raw = {SUPPLY_FAIL, SUPPLY_BELOW_MIN, MANUAL_RESET_N, DELAY_SELECT, TOLERANCE_SELECT};

   // Fail and below-min assumed at reset so outputs start held; button up, select pins open
   rsg_sync #(.W(7), .INIT(7'h7A)) u_sync (
      .clk(CLK),
      .rst_n(RSTN),
      .d(pins_raw),
      .q(pins_s)
   );

   assign {fail_s, below_s, button_s, delay_pin_s, tol_pin_s} = pins_s;

   // ----------------------------------------
   // Single divider chain
   // ----------------------------------------
   logic [DIV_CNT_W-1:0] div_q;
   logic tick_q;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else if (div_q == DIV_CNT_W'(TICK_CYC - 1)) begin
         div_q <= '0;
         tick_q <= 1'b1;
      end else begin
         div_q <= div_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Manual reset debounce
   // ----------------------------------------
   // Both edges need a stable run, so bounce on release cannot start two cycles
   logic button_low_q;
   logic [DEB_CNT_W-1:0] deb_q;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         button_low_q <= 1'b0;
         deb_q <= '0;
      end else if (button_s != button_low_q) begin
         deb_q <= '0;
      end else if (tick_q) begin
         if (deb_q == DEB_CNT_W'(DEB_TICKS - 1)) begin
            button_low_q <= ~button_low_q;
            deb_q <= '0;
         end else begin
            deb_q <= deb_q + 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Three-state decode
   // ----------------------------------------
   function automatic rsg_sel_t decode3(input rsg_pin3_t p);
      rsg_sel_t s;
      s = RSG_SEL_FLOAT;
      if (!p.floating) begin
         s = p.level ? RSG_SEL_HIGH : RSG_SEL_LOW;
      end
      return s;
   endfunction

   rsg_sel_t delay_sel;
   logic [SEQ_CNT_W-1:0] base_d;

   always_comb begin
      delay_sel = decode3(delay_pin_s);
      case (delay_sel)
         RSG_SEL_LOW: base_d = BASE_LOW;
         RSG_SEL_HIGH: base_d = BASE_HIGH;
         default: base_d = BASE_FLOAT;
      endcase
   end

   // ----------------------------------------
   // Tolerance latch
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         SUPPLY_TRIP_POINT <= TOL_RESET;
      end else if (below_s) begin
         SUPPLY_TRIP_POINT <= decode3(tol_pin_s);
      end
   end

   // ----------------------------------------
   // Release sequence
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_HOLD,
      ST_RUN,
      ST_DONE
   } rsg_state_t;

   localparam int N_OUT = $bits(rsg_resets_t);

   rsg_state_t state_q;
   logic [SEQ_CNT_W-1:0] cnt_q;
   logic [SEQ_CNT_W-1:0] lim_q [N_OUT];
   logic [N_OUT-1:0] past_lim;
   logic hold;

   // Manual reset honoured in every state, restarting any sequence in flight
   assign hold = fail_s | button_low_q;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_q <= ST_HOLD;
         cnt_q <= '0;
      end else if (hold) begin
         state_q <= ST_HOLD;
         cnt_q <= '0;
      end else begin
         case (state_q)
            ST_HOLD: begin
               state_q <= ST_RUN;
               cnt_q <= '0;
            end
            ST_RUN: begin
               // Ticks are free running, so one spare tick keeps each delay at its minimum
               if (tick_q) begin
                  cnt_q <= cnt_q + 1'b1;
               end
               if (cnt_q > lim_q[N_OUT-1]) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: state_q <= ST_DONE;
            default: state_q <= ST_HOLD;
         endcase
      end
   end

   // ----------------------------------------
   // Release points
   // ----------------------------------------
   // Products taken once per sequence, so no multiplier sits in the compare path
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         lim_q[0] <= BASE_FLOAT;
         lim_q[1] <= SEQ_CNT_W'(BASE_FLOAT * SECOND_MULT);
         lim_q[2] <= SEQ_CNT_W'(BASE_FLOAT * THIRD_MULT);
      end else if (state_q == ST_HOLD) begin
         // Delay select tracked while held, frozen once the sequence runs
         lim_q[0] <= base_d;
         lim_q[1] <= SEQ_CNT_W'(base_d * SECOND_MULT);
         lim_q[2] <= SEQ_CNT_W'(base_d * THIRD_MULT);
      end
   end

   // ----------------------------------------
   // Per output compare
   // ----------------------------------------
   // One counter feeds all three points, so release order cannot invert
   genvar ch;
   generate
      for (ch = 0; ch < N_OUT; ch++) begin : g_out
         assign past_lim[ch] = cnt_q > lim_q[ch];
      end
   endgenerate

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         RESET_OUT <= '0;
      end else if (hold || state_q == ST_HOLD) begin
         RESET_OUT <= '0;
      end else if (state_q == ST_DONE) begin
         RESET_OUT <= '1;
      end else begin
         RESET_OUT <= rsg_resets_t'(past_lim);
      end
   end

endmodule // rsg_sequencer

/* hdl/rsg_pkg.sv */
package rsg_pkg;

   // ----------------------------------------
   // Three-state select pin as sensed by the pad
   // ----------------------------------------
   typedef struct packed {
      logic floating;
      logic level;
   } rsg_pin3_t;

   typedef enum logic [1:0] {
      RSG_SEL_LOW,
      RSG_SEL_FLOAT,
      RSG_SEL_HIGH
   } rsg_sel_t;

   // Grouped reset outputs
   typedef struct packed {
      logic third_n;
      logic second_n;
      logic first_n;
   } rsg_resets_t;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int TICK_US = 100;
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
   localparam int TICKS_PER_MS = 1000 / TICK_US;

   localparam int DELAY_LOW_MS = 10;
   localparam int DELAY_FLOAT_MS = 20;
   localparam int DELAY_HIGH_MS = 50;
   localparam int SECOND_MULT = 5;
   localparam int THIRD_MULT = 10;

   localparam int MANUAL_RESET_DELAY_US = 1500;
   localparam int DEBOUNCE_TICKS = MANUAL_RESET_DELAY_US / TICK_US;

   localparam int SEQ_CNT_W = 13;
   localparam int DEB_CNT_W = 5;
   localparam int DIV_CNT_W = 16;

   localparam logic [SEQ_CNT_W-1:0] BASE_LOW = SEQ_CNT_W'(DELAY_LOW_MS * TICKS_PER_MS);
   localparam logic [SEQ_CNT_W-1:0] BASE_FLOAT = SEQ_CNT_W'(DELAY_FLOAT_MS * TICKS_PER_MS);
   localparam logic [SEQ_CNT_W-1:0] BASE_HIGH = SEQ_CNT_W'(DELAY_HIGH_MS * TICKS_PER_MS);

   localparam logic [1:0] TOL_RESET = 2'h1;

endpackage : rsg_pkg

/* hdl/rsg_sync.sv */
`timescale 1ns/1ps
module rsg_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ----------------------------------------
   // Per bit: change counts once stages agree
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               q[i] <= INIT[i];
            end else if (s2_q[i] == s3_q[i]) begin
               q[i] <= s3_q[i];
            end
         end
      end
   endgenerate

endmodule // rsg_sync

/* verification/rsg_button.sv */
`timescale 1ns/1ps
module rsg_button (
   input wire logic clk,
   input wire logic press,
   input wire logic [7:0] bounce,
   output logic button_n
);
   logic [7:0] cnt_q = 8'h0;
   // Chatter first, then solid low; pull-up wins when let go
   always @(posedge clk) begin
      if (!press) begin
         cnt_q <= 8'h0;
         button_n <= 1'b1;
      end else if (cnt_q < bounce) begin
         cnt_q <= cnt_q + 8'h1;
         button_n <= ~button_n;
      end else begin
         button_n <= 1'b0;
      end
   end
endmodule // rsg_button

/* verification/rsg_sequencer_chk.sv */
`timescale 1ns/1ps
module rsg_sequencer_chk
   import rsg_pkg::*;
#(parameter int TICK_CYC = 4, parameter int DEB_TICKS = 3) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic SUPPLY_FAIL,
   input wire logic SUPPLY_BELOW_MIN,
   input wire logic MANUAL_RESET_N,
   input wire rsg_resets_t RESET_OUT,
   input wire logic [1:0] SUPPLY_TRIP_POINT
);
   int low_q;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) low_q <= 0;
      else if (MANUAL_RESET_N) low_q <= 0;
      else if (low_q < 1000) low_q <= low_q + 1;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   property p_fail; SUPPLY_FAIL [*8] |-> RESET_OUT == 3'h0; endproperty
   a_fail: assert property (p_fail) else $error("resets up during fail");
   property p_ord1; RESET_OUT.second_n |-> RESET_OUT.first_n; endproperty
   a_ord1: assert property (p_ord1) else $error("second before first");
   property p_ord2; RESET_OUT.third_n |-> RESET_OUT.second_n; endproperty
   a_ord2: assert property (p_ord2) else $error("third before second");
   property p_stay;
      $fell(RESET_OUT.first_n) |-> !$past(MANUAL_RESET_N, 2) || $past(SUPPLY_FAIL, 3) || $past(SUPPLY_FAIL, 5);
   endproperty
   a_stay: assert property (p_stay) else $error("reset without cause");
   property p_man; low_q > (DEB_TICKS + 2) * TICK_CYC + 8 |-> RESET_OUT == 3'h0; endproperty
   a_man: assert property (p_man) else $error("button held, resets up");
   property p_tol; !SUPPLY_BELOW_MIN [*8] |-> $stable(SUPPLY_TRIP_POINT); endproperty
   a_tol: assert property (p_tol) else $error("trip point moved");
   property p_code; SUPPLY_TRIP_POINT != 2'h3; endproperty
   a_code: assert property (p_code) else $error("bad trip code");
   property p_gap2; $rose(RESET_OUT.second_n) |-> $past(RESET_OUT.first_n, 300); endproperty
   a_gap2: assert property (p_gap2) else $error("second too early");
   property p_gap3; $rose(RESET_OUT.third_n) |-> $past(RESET_OUT.second_n, 300); endproperty
   a_gap3: assert property (p_gap3) else $error("third too early");
endmodule // rsg_sequencer_chk
bind rsg_sequencer rsg_sequencer_chk #(.TICK_CYC(TICK_CYC), .DEB_TICKS(DEB_TICKS)) rsg_sequencer_chk_inst (
   .CLK(CLK), .RSTN(RSTN), .SUPPLY_FAIL(SUPPLY_FAIL), .SUPPLY_BELOW_MIN(SUPPLY_BELOW_MIN),
   .MANUAL_RESET_N(MANUAL_RESET_N), .RESET_OUT(RESET_OUT), .SUPPLY_TRIP_POINT(SUPPLY_TRIP_POINT));

/* verification/tb_rsg_sequencer.sv */
`timescale 1ns/1ps
module tb_rsg_sequencer;
   import rsg_pkg::*;
   localparam int T = 4;
   localparam int DT = 3;
   logic CLK, RSTN, SUPPLY_FAIL, SUPPLY_BELOW_MIN, MANUAL_RESET_N, press;
   logic [7:0] bounce;
   rsg_pin3_t DELAY_SELECT, TOLERANCE_SELECT;
   rsg_resets_t RESET_OUT;
   logic [1:0] SUPPLY_TRIP_POINT;
   int err_count, checks_done, c;
   int cyc = 0;
   rsg_sequencer #(.TICK_CYC(T), .DEB_TICKS(DT)) rsg_sequencer_inst (.CLK(CLK), .RSTN(RSTN),
      .SUPPLY_FAIL(SUPPLY_FAIL), .SUPPLY_BELOW_MIN(SUPPLY_BELOW_MIN), .MANUAL_RESET_N(MANUAL_RESET_N),
      .DELAY_SELECT(DELAY_SELECT), .TOLERANCE_SELECT(TOLERANCE_SELECT), .RESET_OUT(RESET_OUT),
      .SUPPLY_TRIP_POINT(SUPPLY_TRIP_POINT));
   rsg_button rsg_button_inst (.clk(CLK), .press(press), .bounce(bounce), .button_n(MANUAL_RESET_N));
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic cycles(input int k);
      repeat (k) @(negedge CLK);
   endtask
   // Cycles until output b is up, or all down for b==3
   task automatic wait_for(input int b, output int n);
      n = 0;
      while (n < 30000 && (b == 3 ? RESET_OUT !== 3'h0 : RESET_OUT[b] !== 1'b1)) begin
         @(negedge CLK);
         n++;
      end
   endtask
   task automatic t_tol();
      rsg_pin3_t s[3] = '{2'h0, 2'h2, 2'h1};
      for (int i = 0; i < 3; i++) begin
         @(posedge CLK) TOLERANCE_SELECT <= s[i];
         cycles(10);
         chk(SUPPLY_TRIP_POINT, i);
      end
      @(posedge CLK) SUPPLY_BELOW_MIN <= 1'b0;
      cycles(10);
      @(posedge CLK) TOLERANCE_SELECT <= 2'h0;
      cycles(10);
      chk(SUPPLY_TRIP_POINT, 2);
      $display("t_tol done");
   endtask
   task automatic t_seq(input rsg_pin3_t sel, input int b);
      int c1, c2, c3;
      @(posedge CLK) begin
         DELAY_SELECT <= sel;
         SUPPLY_FAIL <= 1'b1;
      end
      cycles(10);
      chk(RESET_OUT, 3'h0);
      @(posedge CLK) SUPPLY_FAIL <= 1'b0;
      wait_for(0, c1);
      chk(c1 >= b * T && c1 <= (b + 2) * T + 8, 1);
      wait_for(1, c2);
      chk(c1 + c2 >= 5 * b * T && c1 + c2 <= (5 * b + 2) * T + 8, 1);
      wait_for(2, c3);
      chk(c1 + c2 + c3 >= 10 * b * T && c1 + c2 + c3 <= (10 * b + 2) * T + 8, 1);
      $display("t_seq %0d done", b);
   endtask
   task automatic t_man();
      @(posedge CLK) begin
         DELAY_SELECT <= 2'h0;
         bounce <= 8'h6;
         press <= 1'b1;
      end
      wait_for(3, c);
      chk(c >= (DT - 1) * T && c <= 6 + (DT + 2) * T + 8, 1);
      cycles(20);
      chk(RESET_OUT, 3'h0);
      @(posedge CLK) press <= 1'b0;
      wait_for(0, c);
      chk(c >= BASE_LOW * T && c <= (BASE_LOW + DT + 3) * T + 16, 1);
      @(posedge CLK) SUPPLY_FAIL <= 1'b1;
      cycles(10);
      chk(RESET_OUT, 3'h0);
      @(posedge CLK) SUPPLY_FAIL <= 1'b0;
      wait_for(0, c);
      chk(c >= BASE_LOW * T, 1);
      wait_for(2, c);
      // Short chattering press must be ignored
      @(posedge CLK) begin
         bounce <= 8'h2;
         press <= 1'b1;
      end
      cycles(5);
      @(posedge CLK) press <= 1'b0;
      cycles(40);
      chk(RESET_OUT, 3'h7);
      $display("t_man done");
   endtask
   // Upstream sequencer's third output on the manual input: clean edges, long low
   task automatic t_casc();
      @(posedge CLK) begin
         bounce <= 8'h0;
         press <= 1'b1;
      end
      wait_for(3, c);
      chk(c >= (DT - 1) * T && c <= (DT + 2) * T + 8, 1);
      cycles(100);
      chk(RESET_OUT, 3'h0);
      @(posedge CLK) press <= 1'b0;
      wait_for(2, c);
      chk(c >= 10 * BASE_LOW * T && c <= (10 * BASE_LOW + DT + 3) * T + 16, 1);
      $display("t_casc done");
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      RSTN = 1'b0;
      SUPPLY_FAIL = 1'b1;
      SUPPLY_BELOW_MIN = 1'b1;
      press = 1'b0;
      bounce = 8'h0;
      DELAY_SELECT = 2'h0;
      TOLERANCE_SELECT = 2'h0;
      err_count = 0;
      checks_done = 0;
      cycles(16);
      @(posedge CLK) RSTN <= 1'b1;
      t_tol();
      t_seq(2'h0, BASE_LOW);
      t_seq(2'h2, BASE_FLOAT);
      t_seq(2'h1, BASE_HIGH);
      t_man();
      t_casc();
      final_report();
   end
endmodule // tb_rsg_sequencer
